// [rtl/dmsd_consts.vh]
/*
 constants for the data memory space decoder: sfr addresses, bit positions,
 memory sizes and limits. assumes it is included once per design file.
*/
`ifndef DMSD_CONSTS_VH
`define DMSD_CONSTS_VH
`define DMSD_AUX_FUNC_ADDR 8'h8e
`define DMSD_AUX_PTR_ADDR 8'ha2
`define DMSD_PTR_LOW_ADDR 8'h82
`define DMSD_PTR_HIGH_ADDR 8'h83
`define DMSD_XRAM_DIS_BIT 1
`define DMSD_PTR_SEL_BIT 0
`define DMSD_AUX_FUNC_RESET 8'h00
`define DMSD_AUX_PTR_RESET 8'h00
`define DMSD_UPPER_START 8'h80
`define DMSD_XRAM_LIMIT 16'h0300
`define DMSD_IRAM_DEPTH 256
`define DMSD_XRAM_DEPTH 768
`define DMSD_PTR_RESET 16'h0000
`define DMSD_OP_NONE 3'h0
`define DMSD_OP_DIRECT 3'h1
`define DMSD_OP_INDIRECT 3'h2
`define DMSD_OP_STACK 3'h3
`define DMSD_OP_XRI 3'h4
`define DMSD_OP_XPTR 3'h5
`define DMSD_OP_AUXINC 3'h6
`endif

// [rtl/dmsd_ext_bus.v]
/*
 external data bus cycle engine: address phase with latch enable, then data
 phase with read or write strobe (active low). assumes a start pulse only
 while idle; read data on the port 0 inputs is sampled in the strobe phase.
*/
`include "dmsd_consts.vh"
`default_nettype none
module dmsd_ext_bus #(
   parameter STROBE_CYCLES = 2
)(
   input wire clk,
   input wire srst,
   input wire start,
   input wire is_write,
   input wire wide_addr,
   input wire [15:0] addr,
   input wire [7:0] wdata,
   input wire [7:0] port0_in,
   output reg [7:0] port0_out,
   output reg port0_oe,
   output reg [7:0] port2_out,
   output reg port2_oe,
   output reg addr_latch,
   output reg write_strobe_n,
   output reg read_strobe_n,
   output reg [7:0] rdata,
   output wire busy,
   output reg done
);
   localparam ST_IDLE = 2'h0;
   localparam ST_ADDR = 2'h1;
   localparam ST_DATA = 2'h2;
   localparam ST_END = 2'h3;
   reg [1:0] state_reg;
   reg [3:0] count_reg;
   reg wr_reg;
   assign busy = (state_reg != ST_IDLE);
   ////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (srst)
      begin
         state_reg <= ST_IDLE;
         count_reg <= 4'h0;
         wr_reg <= 1'b0;
         port0_out <= 8'h00;
         port0_oe <= 1'b0;
         port2_out <= 8'h00;
         port2_oe <= 1'b0;
         addr_latch <= 1'b0;
         write_strobe_n <= 1'b1;
         read_strobe_n <= 1'b1;
         rdata <= 8'h00;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         case (state_reg)
            ST_IDLE:
            begin
               if (start)
               begin
                  wr_reg <= is_write;
                  port0_out <= addr[7:0];
                  port0_oe <= 1'b1;
                  port2_out <= addr[15:8];
                  port2_oe <= wide_addr;
                  addr_latch <= 1'b1;
                  state_reg <= ST_ADDR;
               end
            end
            ST_ADDR:
            begin
               addr_latch <= 1'b0;
               count_reg <= STROBE_CYCLES[3:0];
               port0_out <= wdata;
               port0_oe <= wr_reg;
               write_strobe_n <= ~wr_reg;
               read_strobe_n <= wr_reg;
               state_reg <= ST_DATA;
            end
            ST_DATA:
            begin
               if (count_reg == 4'h1)
               begin
                  if (!wr_reg)
                     rdata <= port0_in;
                  write_strobe_n <= 1'b1;
                  read_strobe_n <= 1'b1;
                  state_reg <= ST_END;
               end
               else
                  count_reg <= count_reg - 4'h1;
            end
            ST_END:
            begin
               port0_oe <= 1'b0;
               port2_oe <= 1'b0;
               done <= 1'b1;
               state_reg <= ST_IDLE;
            end
            default:
               state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [rtl/dmsd_top.v]
/*
 data memory space decoder: steers core data accesses to lower/upper internal
 ram, sfrs, on-chip expanded ram or the external multiplexed bus; holds the
 auxiliary registers and the dual data pointers. assumes the core holds a
 request steady until ack and issues one request at a time.
*/
`include "dmsd_consts.vh"
`default_nettype none
module dmsd_top #(
   parameter STROBE_CYCLES = 2
)(
   input wire clk,
   input wire srst,
   input wire req,
   input wire [2:0] op,
   input wire is_write,
   input wire [7:0] addr8,
   input wire [7:0] wdata,
   output reg [7:0] rdata,
   output wire ack,
   output wire [15:0] data_pointer,
   output wire onchip_xram_disable,
   output wire pointer_select,
   input wire [7:0] port0_in,
   output wire [7:0] port0_out,
   output wire port0_oe,
   output wire [7:0] port2_out,
   output wire port2_oe,
   output wire addr_latch,
   output wire write_strobe_n,
   output wire read_strobe_n,
   output wire [7:0] sfr_addr,
   output wire [7:0] sfr_wdata,
   output wire sfr_write,
   input wire [7:0] sfr_rdata
);
   reg [7:0] iram [0:`DMSD_IRAM_DEPTH-1];
   reg [7:0] xram [0:`DMSD_XRAM_DEPTH-1];
   reg [7:0] aux_function_control_reg;
   reg [7:0] aux_pointer_control_reg;
   reg [15:0] data_pointer_first_reg;
   reg [15:0] data_pointer_second_reg;
   reg ack_reg;
   reg bus_pending_reg;
   reg [7:0] aux_pointer_control_next;
   wire bus_busy;
   wire bus_done;
   wire [7:0] bus_rdata;
   wire [15:0] xaddr;
   wire xram_hit;
   wire use_bus;
   wire int_req;
   wire bus_start;
   reg [7:0] sfr_read_value;
   ////////////////////////////////////////////////////////////////////////
   // functions
   function sfr_space;
      input [7:0] a;
      begin
         sfr_space = (a >= `DMSD_UPPER_START);
      end
   endfunction
   function sel_byte;
      input [7:0] a;
      input [7:0] target;
      begin
         sel_byte = (a == target);
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // decode
   assign onchip_xram_disable = aux_function_control_reg[`DMSD_XRAM_DIS_BIT];
   assign pointer_select = aux_pointer_control_reg[`DMSD_PTR_SEL_BIT];
   assign data_pointer = pointer_select ? data_pointer_second_reg : data_pointer_first_reg;
   assign xaddr = (op == `DMSD_OP_XPTR) ? data_pointer : {8'h00, addr8};
   assign xram_hit = !onchip_xram_disable &&
      ((op == `DMSD_OP_XRI) || (xaddr < `DMSD_XRAM_LIMIT));
   assign use_bus = ((op == `DMSD_OP_XRI) || (op == `DMSD_OP_XPTR)) && !xram_hit;
   assign int_req = req && !ack_reg && !use_bus;
   assign bus_start = req && use_bus && !bus_pending_reg && !bus_busy;
   assign ack = ack_reg || bus_done;
   assign sfr_addr = addr8;
   assign sfr_wdata = wdata;
   assign sfr_write = int_req && is_write && (op == `DMSD_OP_DIRECT) && sfr_space(addr8) &&
      !sel_byte(addr8, `DMSD_AUX_FUNC_ADDR) && !sel_byte(addr8, `DMSD_AUX_PTR_ADDR) &&
      !sel_byte(addr8, `DMSD_PTR_LOW_ADDR) && !sel_byte(addr8, `DMSD_PTR_HIGH_ADDR);
   always @*
   begin
      if (sel_byte(addr8, `DMSD_AUX_FUNC_ADDR))
         sfr_read_value = aux_function_control_reg;
      else if (sel_byte(addr8, `DMSD_AUX_PTR_ADDR))
         sfr_read_value = aux_pointer_control_reg;
      else if (sel_byte(addr8, `DMSD_PTR_LOW_ADDR))
         sfr_read_value = data_pointer[7:0];
      else if (sel_byte(addr8, `DMSD_PTR_HIGH_ADDR))
         sfr_read_value = data_pointer[15:8];
      else
         sfr_read_value = sfr_rdata;
   end
   always @*
   begin
      aux_pointer_control_next = aux_pointer_control_reg;
      if (int_req && (op == `DMSD_OP_AUXINC))
         aux_pointer_control_next = aux_pointer_control_reg + 8'h01;
      else if (int_req && is_write && (op == `DMSD_OP_DIRECT) && sel_byte(addr8, `DMSD_AUX_PTR_ADDR))
         aux_pointer_control_next = wdata;
   end
   ////////////////////////////////////////////////////////////////////////
   // register and memory updates
   always @(posedge clk)
   begin
      if (srst)
      begin
         aux_function_control_reg <= `DMSD_AUX_FUNC_RESET;
         aux_pointer_control_reg <= `DMSD_AUX_PTR_RESET;
         data_pointer_first_reg <= `DMSD_PTR_RESET;
         data_pointer_second_reg <= `DMSD_PTR_RESET;
         ack_reg <= 1'b0;
         bus_pending_reg <= 1'b0;
         rdata <= 8'h00;
      end
      else
      begin
         ack_reg <= int_req;
         aux_pointer_control_reg <= aux_pointer_control_next;
         if (bus_start)
            bus_pending_reg <= 1'b1;
         else if (bus_done)
            bus_pending_reg <= 1'b0;
         // read data lands in the last busy cycle so it stands with ack
         if (bus_pending_reg && bus_busy && !is_write && !addr_latch && write_strobe_n && read_strobe_n)
            rdata <= bus_rdata;
         if (int_req)
         begin
            case (op)
               `DMSD_OP_DIRECT:
               begin
                  if (!sfr_space(addr8))
                  begin
                     if (is_write)
                        iram[addr8] <= wdata;
                     rdata <= iram[addr8];
                  end
                  else
                  begin
                     rdata <= sfr_read_value;
                     if (is_write && sel_byte(addr8, `DMSD_AUX_FUNC_ADDR))
                        aux_function_control_reg <= wdata;
                     if (is_write && sel_byte(addr8, `DMSD_PTR_LOW_ADDR))
                     begin
                        if (pointer_select)
                           data_pointer_second_reg[7:0] <= wdata;
                        else
                           data_pointer_first_reg[7:0] <= wdata;
                     end
                     if (is_write && sel_byte(addr8, `DMSD_PTR_HIGH_ADDR))
                     begin
                        if (pointer_select)
                           data_pointer_second_reg[15:8] <= wdata;
                        else
                           data_pointer_first_reg[15:8] <= wdata;
                     end
                  end
               end
               `DMSD_OP_INDIRECT, `DMSD_OP_STACK:
               begin
                  if (is_write)
                     iram[addr8] <= wdata;
                  rdata <= iram[addr8];
               end
               `DMSD_OP_XRI, `DMSD_OP_XPTR:
               begin
                  if (is_write)
                     xram[xaddr[9:0]] <= wdata;
                  rdata <= xram[xaddr[9:0]];
               end
               default:
                  rdata <= rdata;
            endcase
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // external bus cycles, only started for off-chip moves
   dmsd_ext_bus #(
      .STROBE_CYCLES(STROBE_CYCLES)
   ) u_bus (
      .clk(clk),
      .srst(srst),
      .start(bus_start),
      .is_write(is_write),
      .wide_addr(op == `DMSD_OP_XPTR),
      .addr(xaddr),
      .wdata(wdata),
      .port0_in(port0_in),
      .port0_out(port0_out),
      .port0_oe(port0_oe),
      .port2_out(port2_out),
      .port2_oe(port2_oe),
      .addr_latch(addr_latch),
      .write_strobe_n(write_strobe_n),
      .read_strobe_n(read_strobe_n),
      .rdata(bus_rdata),
      .busy(bus_busy),
      .done(bus_done)
   );
endmodule
`default_nettype wire

// [bench/dmsd_xmem.sv]
/* external data memory on the multiplexed bus.
   assumes address latch, then one active low strobe per cycle. */
`default_nettype none
module dmsd_xmem (
   input wire logic clk,
   input wire logic [7:0] port0_out,
   input wire logic [7:0] port2_out,
   input wire logic port2_oe,
   input wire logic addr_latch,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   output logic [7:0] port0_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [0:65535];
   logic [15:0] a;
   ////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (addr_latch)
         a <= {port2_oe ? port2_out : 8'h00, port0_out};
   end
   always @(posedge write_strobe_n)
      mem[a] <= port0_out;
   // released bus shows the inverse of the byte held on port0_out
   assign port0_in = !read_strobe_n ? mem[a] : ~port0_out;
endmodule
`default_nettype wire

// [bench/dmsd_checker.sv]
/* checker: bus timing and decode of dmsd_top.
   assumes the core holds each request until ack. */
`default_nettype none
module dmsd_checker #(
   parameter int STROBE_CYCLES = 2
)(
   input wire logic clk,
   input wire logic srst,
   input wire logic req,
   input wire logic [2:0] op,
   input wire logic is_write,
   input wire logic [7:0] addr8,
   input wire logic ack,
   input wire logic [15:0] data_pointer,
   input wire logic onchip_xram_disable,
   input wire logic pointer_select,
   input wire logic port0_oe,
   input wire logic port2_oe,
   input wire logic addr_latch,
   input wire logic write_strobe_n,
   input wire logic read_strobe_n,
   input wire logic sfr_write
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   ////////////////////////////////////////////////////////////
   strobe_excl_a: assert property (write_strobe_n || read_strobe_n) else $error("both strobes low");
   latch_strobe_a: assert property (addr_latch |=> !write_strobe_n || !read_strobe_n) else $error("no strobe");
   write_len_a: assert property ($fell(write_strobe_n) |-> ##STROBE_CYCLES $rose(write_strobe_n))
      else $error("write strobe length");
   end_ack_a: assert property ($rose(read_strobe_n) |=> ack) else $error("no ack after read");
   write_drive_a: assert property (!write_strobe_n |-> port0_oe) else $error("port0 not driven");
   read_release_a: assert property (!read_strobe_n |-> !port0_oe) else $error("port0 driven in read");
   high_byte_a: assert property (port2_oe |-> req && op == 3'h5) else $error("port2 driven");
   xram_quiet_a: assert property (req && op == 3'h4 && !onchip_xram_disable |->
      write_strobe_n && read_strobe_n && !addr_latch) else $error("bus used for xram");
   low_ptr_a: assert property (req && op == 3'h5 && !onchip_xram_disable && data_pointer < 16'h0300 |->
      write_strobe_n && read_strobe_n && !addr_latch) else $error("bus used below limit");
   bus_start_a: assert property ($rose(req) && op[2:1] == 2'b10 &&
      (onchip_xram_disable || (op[0] && data_pointer >= 16'h0300)) |-> ##[1:2] addr_latch) else $error("no bus");
   sfr_only_a: assert property (sfr_write |-> op == 3'h1 && addr8[7] && is_write) else $error("sfr write");
   flip_a: assert property (req && op == 3'h6 && ack |-> ##1 pointer_select != $past(pointer_select, 2))
      else $error("select not flipped");
   cover property ($rose(addr_latch) && port2_oe);
   cover property (!write_strobe_n && !onchip_xram_disable);
   cover property (ack && op == 3'h6);
endmodule
bind dmsd_top dmsd_checker #(.STROBE_CYCLES(STROBE_CYCLES)) chk_i (.clk(clk), .srst(srst), .req(req),
   .op(op), .is_write(is_write), .addr8(addr8), .ack(ack), .data_pointer(data_pointer),
   .onchip_xram_disable(onchip_xram_disable), .pointer_select(pointer_select), .port0_oe(port0_oe),
   .port2_oe(port2_oe), .addr_latch(addr_latch), .write_strobe_n(write_strobe_n),
   .read_strobe_n(read_strobe_n), .sfr_write(sfr_write));
`default_nettype wire

// [bench/dmsd_top_tb.sv]
/* bench: core-side stimulus for dmsd_top with the external memory model.
   assumes two strobe cycles per bus access. */
`default_nettype none
module dmsd_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, req, is_write, ack, onchip_xram_disable, pointer_select, port0_oe, port2_oe;
   logic addr_latch, write_strobe_n, read_strobe_n, sfr_write;
   logic [2:0] op;
   logic [7:0] addr8, wdata, rdata, port0_in, port0_out, port2_out, sfr_addr, sfr_wdata, sfr_rdata, rd;
   logic [15:0] data_pointer, sa;
   logic sw;
   int err_count = 0;
   int comparisons = 0;
   dmsd_top #(.STROBE_CYCLES(2)) dut (.clk(clk), .srst(srst), .req(req), .op(op), .is_write(is_write),
      .addr8(addr8), .wdata(wdata), .rdata(rdata), .ack(ack), .data_pointer(data_pointer),
      .onchip_xram_disable(onchip_xram_disable), .pointer_select(pointer_select), .port0_in(port0_in),
      .port0_out(port0_out), .port0_oe(port0_oe), .port2_out(port2_out), .port2_oe(port2_oe),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_rdata(sfr_rdata));
   dmsd_xmem xmem (.clk(clk), .port0_out(port0_out), .port2_out(port2_out), .port2_oe(port2_oe),
      .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
      .port0_in(port0_in));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic stop_test;
      if (err_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic acc(input logic [2:0] o, input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge clk);
      req <= 1'b1;
      op <= o;
      is_write <= w;
      addr8 <= a;
      wdata <= d;
      @(negedge clk);
      sw = sfr_write;
      sa = {sfr_addr, sfr_wdata};
      for (n = 0; n < 20 && ack !== 1'b1; n++) @(negedge clk);
      chk(ack, 1'b1);
      rd = rdata;
      @(posedge clk);
      req <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(negedge clk);
      chk(onchip_xram_disable, 1'b0);
      chk(pointer_select, 1'b0);
      chk({write_strobe_n, read_strobe_n}, 2'h3);
   endtask
   task automatic t_iram;
      acc(3'h2, 1'b1, 8'h90, 8'h55);
      chk(sw, 1'b0);
      acc(3'h1, 1'b1, 8'h90, 8'haa);
      chk(sw, 1'b1);
      chk(sa, 16'h90aa);
      acc(3'h2, 1'b0, 8'h90, 8'h00);
      chk(rd, 8'h55);
      acc(3'h1, 1'b0, 8'h90, 8'h00);
      chk(rd, 8'hc3);
      acc(3'h1, 1'b1, 8'h10, 8'h11);
      acc(3'h2, 1'b0, 8'h10, 8'h00);
      chk(rd, 8'h11);
      acc(3'h3, 1'b0, 8'h90, 8'h00);
      chk(rd, 8'h55);
   endtask
   task automatic t_xram;
      acc(3'h1, 1'b1, 8'h82, 8'ha0);
      acc(3'h5, 1'b1, 8'h00, 8'h3c);
      acc(3'h4, 1'b0, 8'ha0, 8'h00);
      chk(rd, 8'h3c);
      acc(3'h1, 1'b1, 8'h83, 8'h03);
      acc(3'h1, 1'b1, 8'h82, 8'h00);
      acc(3'h5, 1'b1, 8'h00, 8'h77);
      chk(xmem.mem[16'h0300], 8'h77);
      acc(3'h5, 1'b0, 8'h00, 8'h00);
      chk(rd, 8'h77);
   endtask
   task automatic t_disable;
      acc(3'h1, 1'b1, 8'h8e, 8'h02);
      chk(onchip_xram_disable, 1'b1);
      acc(3'h4, 1'b1, 8'h40, 8'h99);
      chk(xmem.mem[16'h0040], 8'h99);
      acc(3'h1, 1'b1, 8'h83, 8'h00);
      acc(3'h1, 1'b1, 8'h82, 8'ha0);
      acc(3'h5, 1'b1, 8'h00, 8'h66);
      chk(xmem.mem[16'h00a0], 8'h66);
      acc(3'h1, 1'b1, 8'h8e, 8'h00);
   endtask
   task automatic t_data_pointer;
      acc(3'h6, 1'b0, 8'h00, 8'h00);
      chk(pointer_select, 1'b1);
      chk(data_pointer, 16'h0000);
      acc(3'h1, 1'b1, 8'h82, 8'h34);
      acc(3'h1, 1'b1, 8'h83, 8'h12);
      chk(data_pointer, 16'h1234);
      acc(3'h6, 1'b0, 8'h00, 8'h00);
      chk(data_pointer, 16'h00a0);
   endtask
   ////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      err_count++;
      stop_test();
   end
   initial
   begin
      srst = 1'b1;
      req = 1'b0;
      op = 3'h0;
      is_write = 1'b0;
      addr8 = 8'h00;
      wdata = 8'h00;
      sfr_rdata = 8'hc3;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_iram();
      t_xram();
      t_disable();
      t_data_pointer();
      stop_test();
   end
endmodule
`default_nettype wire
